// ===== inc/coi_map.svh
`ifndef COI_MAP_SVH
`define COI_MAP_SVH

// register byte addresses on the special function register bus
`define COI_ADDR_BT1 8'hb4
`define COI_ADDR_STAT_HI 8'hba
`define COI_ADDR_STAT_LO 8'hbb
`define COI_ADDR_EN_HI 8'hc2
`define COI_ADDR_EN_LO 8'hc3

// field layout
`define COI_BRP_LSB 1
`define COI_BRP_MSB 6
`define COI_BRP_W 6
`define COI_HI_OBJS 7
`define COI_LO_OBJS 8
`define COI_HI_BASE 8
`define COI_NUM_OBJS 15

// reset values
`define COI_RST_BYTE 8'h00
`define COI_RST_BRP 6'h00

`endif

// ===== inc/coi_pkg.sv
package coi_pkg;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] en;
    } coi_bank_st_t;

    typedef struct packed {
        logic [5:0] brp;
        logic [5:0] cnt;
        logic tick;
    } coi_presc_st_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic irq;
    } coi_top_st_t;

endpackage : coi_pkg

// ===== inc/coi_sfr_if.sv
`timescale 1ns/1ps

interface coi_sfr_if;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;

    modport master (
        output wr,
        output addr,
        output wdata
    );

    modport slave (
        input wr,
        input addr,
        input wdata
    );
endinterface : coi_sfr_if

// ===== hw/coi_irq_bank.sv
`timescale 1ns/1ps
`include "coi_map.svh"

module coi_irq_bank
    import coi_pkg::*;
#(
    parameter int N = 8,
    parameter logic [7:0] EN_ADDR = `COI_ADDR_EN_LO
)
(
    input wire logic clk,
    input wire logic rst,
    coi_sfr_if.slave bus,
    input wire logic [N-1:0] cond,
    output logic [7:0] flags,
    output logic [7:0] en
);

    localparam logic [7:0] MASK = 8'((9'h001 << N) - 9'h001);

    coi_bank_st_t st;
    coi_bank_st_t next_st;

    always_comb
    begin
        next_st = st;
        // flag mirrors the object's pending condition; no write path exists
        next_st.flags = 8'(cond) & MASK;
        if (bus.wr && bus.addr == EN_ADDR)
        begin
            next_st.en = bus.wdata & MASK;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '{flags: `COI_RST_BYTE, en: `COI_RST_BYTE};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign flags = st.flags;
    assign en = st.en;

endmodule : coi_irq_bank

// ===== hw/coi_prescaler.sv
`timescale 1ns/1ps
`include "coi_map.svh"

module coi_prescaler
    import coi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    coi_sfr_if.slave bus,
    output logic [5:0] brp,
    output logic tick
);

    coi_presc_st_t st;
    coi_presc_st_t next_st;
    logic hit;

    assign hit = bus.wr && bus.addr == `COI_ADDR_BT1;

    always_comb
    begin
        next_st = st;
        if (hit)
        begin
            // reserved bits 7 and 0 are not stored
            next_st.brp = bus.wdata[`COI_BRP_MSB:`COI_BRP_LSB];
            next_st.cnt = 6'h00;
            next_st.tick = 1'b0;
        end
        else if (st.cnt == st.brp)
        begin
            // one scaled clock every brp+1 input clocks
            next_st.cnt = 6'h00;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + 6'h01;
            next_st.tick = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '{brp: `COI_RST_BRP, cnt: 6'h00, tick: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign brp = st.brp;
    assign tick = st.tick;

    // helper: cycles since the last tick, and whether the period ran untouched
    logic [6:0] gap;
    logic clean;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gap <= 7'h00;
            clean <= 1'b0;
        end
        else
        begin
            gap <= (st.tick || hit) ? 7'h00 : gap + 7'h01;
            clean <= hit ? 1'b0 : (st.tick ? 1'b1 : clean);
        end
    end

    a_tick_period: assert property (@(posedge clk) disable iff (rst)
        (st.tick && clean && !$past(hit)) |-> gap == {1'b0, st.brp})
        else $error("scaled clock period differs from prescaler plus one");

    a_tick_after_write: assert property (@(posedge clk) disable iff (rst)
        hit |=> !st.tick ##0 st.cnt == 6'h00)
        else $error("prescaler write did not restart the count");

    c_tick_seen: cover property (@(posedge clk) disable iff (rst)
        st.tick && st.brp != 6'h00);

endmodule : coi_prescaler

// ===== hw/coi_top.sv
`timescale 1ns/1ps
`include "coi_map.svh"

module coi_top
    import coi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [14:0] obj_irq_cond,
    output logic [7:0] sfr_rdata,
    output logic obj_irq_req,
    output logic scl_tick,
    output logic [5:0] baud_prescaler_field
);

    coi_sfr_if bus ();

    assign bus.wr = sfr_wr;
    assign bus.addr = sfr_addr;
    assign bus.wdata = sfr_wdata;

    logic [7:0] object_irq_flags_upper;
    logic [7:0] object_irq_flags_lower;
    logic [7:0] object_irq_enables_upper;
    logic [7:0] object_irq_enables_lower;

    // objects 8..14 land on bits 0..6 of the upper pair
    coi_irq_bank #(
        .N(`COI_HI_OBJS),
        .EN_ADDR(`COI_ADDR_EN_HI)
    ) u_bank_hi (
        .clk(clk),
        .rst(rst),
        .bus(bus),
        .cond(obj_irq_cond[`COI_NUM_OBJS-1:`COI_HI_BASE]),
        .flags(object_irq_flags_upper),
        .en(object_irq_enables_upper)
    );

    coi_irq_bank #(
        .N(`COI_LO_OBJS),
        .EN_ADDR(`COI_ADDR_EN_LO)
    ) u_bank_lo (
        .clk(clk),
        .rst(rst),
        .bus(bus),
        .cond(obj_irq_cond[`COI_HI_BASE-1:0]),
        .flags(object_irq_flags_lower),
        .en(object_irq_enables_lower)
    );

    // bit timing can be rewritten by software at any time; a write restarts the count
    coi_prescaler u_presc (
        .clk(clk),
        .rst(rst),
        .bus(bus),
        .brp(baud_prescaler_field),
        .tick(scl_tick)
    );

    coi_top_st_t st;
    coi_top_st_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.irq = |((object_irq_flags_upper & object_irq_enables_upper)
            | (object_irq_flags_lower & object_irq_enables_lower));
        if (sfr_rd)
        begin
            if (sfr_addr == `COI_ADDR_STAT_HI)
            begin
                next_st.rdata = object_irq_flags_upper;
            end
            else if (sfr_addr == `COI_ADDR_STAT_LO)
            begin
                next_st.rdata = object_irq_flags_lower;
            end
            else if (sfr_addr == `COI_ADDR_EN_HI)
            begin
                next_st.rdata = object_irq_enables_upper;
            end
            else if (sfr_addr == `COI_ADDR_EN_LO)
            begin
                next_st.rdata = object_irq_enables_lower;
            end
            else if (sfr_addr == `COI_ADDR_BT1)
            begin
                // reserved bits 7 and 0 read as zero
                next_st.rdata = {1'b0, baud_prescaler_field, 1'b0};
            end
            else
            begin
                next_st.rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '{rdata: `COI_RST_BYTE, irq: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign obj_irq_req = st.irq;

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    a_flag_lower_map: assert property (
        object_irq_flags_lower == $past(obj_irq_cond[7:0]))
        else $error("lower status flags do not follow objects 0 to 7");

    a_flag_upper_map: assert property (
        object_irq_flags_upper == {1'b0, $past(obj_irq_cond[14:8])})
        else $error("upper status flags do not follow objects 8 to 14");

    a_flag_set_active: assert property (
        $rose(obj_irq_cond[0]) |=> object_irq_flags_lower[0])
        else $error("object interrupt did not show in its flag");

    a_flag_set_seven: assert property (
        $rose(obj_irq_cond[7]) |=> object_irq_flags_lower[7])
        else $error("object 7 interrupt did not show in lower bit 7");

    a_flag_set_upper: assert property (
        $rose(obj_irq_cond[11]) |=> object_irq_flags_upper[3])
        else $error("object 11 interrupt did not show in upper bit 3");

    a_flag_set_top: assert property (
        $rose(obj_irq_cond[14]) |=> object_irq_flags_upper[6])
        else $error("object 14 interrupt did not show in upper bit 6");

    // a flag copies the condition one edge late, so it falls one edge after it
    a_flag_clear_cause: assert property (
        $fell(object_irq_flags_upper[6]) |-> $past(!obj_irq_cond[14]))
        else $error("flag dropped while its condition was still pending");

    a_flag_drop_upper: assert property (
        $fell(object_irq_flags_upper[3]) |-> $past(!obj_irq_cond[11]))
        else $error("upper flag dropped while its condition was still pending");

    a_flag_clear_lower: assert property (
        $fell(object_irq_flags_lower[0]) |-> $past(!obj_irq_cond[0]))
        else $error("lower flag dropped while its condition was still pending");

    a_status_ro_write: assert property (
        (sfr_wr && sfr_addr == `COI_ADDR_STAT_LO)
        |=> object_irq_flags_lower == $past(obj_irq_cond[7:0]))
        else $error("write to status register changed the flags");

    a_status_hi_ro: assert property (
        (sfr_wr && sfr_addr == `COI_ADDR_STAT_HI)
        |=> object_irq_flags_upper == {1'b0, $past(obj_irq_cond[14:8])})
        else $error("write to upper status register changed the flags");

    a_enable_lo_write: assert property (
        (sfr_wr && sfr_addr == `COI_ADDR_EN_LO)
        |=> object_irq_enables_lower == $past(sfr_wdata))
        else $error("lower enable register did not take the write");

    a_enable_hi_write: assert property (
        (sfr_wr && sfr_addr == `COI_ADDR_EN_HI)
        |=> object_irq_enables_upper == {1'b0, $past(sfr_wdata[6:0])})
        else $error("upper enable register mapped wrongly");

    // enables change only on their own write
    a_enable_lo_hold: assert property (
        !(sfr_wr && sfr_addr == `COI_ADDR_EN_LO) |=> $stable(object_irq_enables_lower))
        else $error("lower enable register changed without a write");

    a_enable_hi_hold: assert property (
        !(sfr_wr && sfr_addr == `COI_ADDR_EN_HI) |=> $stable(object_irq_enables_upper))
        else $error("upper enable register changed without a write");

    // reserved top bits of the upper pair are never stored
    a_upper_bit_seven: assert property (
        !object_irq_flags_upper[7] && !object_irq_enables_upper[7])
        else $error("reserved bit 7 of an upper register is set");

    // read data is the register's value at the read edge
    a_read_stat_hi: assert property (
        (sfr_rd && sfr_addr == `COI_ADDR_STAT_HI)
        |=> sfr_rdata == $past(object_irq_flags_upper))
        else $error("upper status read returned the wrong byte");

    a_read_stat_lo: assert property (
        (sfr_rd && sfr_addr == `COI_ADDR_STAT_LO)
        |=> sfr_rdata == $past(object_irq_flags_lower))
        else $error("lower status read returned the wrong byte");

    a_read_en_hi: assert property (
        (sfr_rd && sfr_addr == `COI_ADDR_EN_HI)
        |=> sfr_rdata == $past(object_irq_enables_upper))
        else $error("upper enable read returned the wrong byte");

    a_read_en_lo: assert property (
        (sfr_rd && sfr_addr == `COI_ADDR_EN_LO)
        |=> sfr_rdata == $past(object_irq_enables_lower))
        else $error("lower enable read returned the wrong byte");

    // unmapped addresses read back as zero
    a_read_unmapped: assert property (
        (sfr_rd && sfr_addr != `COI_ADDR_BT1 && sfr_addr != `COI_ADDR_STAT_HI
        && sfr_addr != `COI_ADDR_STAT_LO && sfr_addr != `COI_ADDR_EN_HI
        && sfr_addr != `COI_ADDR_EN_LO) |=> sfr_rdata == 8'h00)
        else $error("unmapped read did not return zero");

    a_rdata_hold: assert property (
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

    // request is registered from the enabled flags
    a_irq_req_follow: assert property (
        ((object_irq_flags_lower & object_irq_enables_lower) != 8'h00)
        |=> obj_irq_req)
        else $error("request not raised for an enabled pending object");

    a_req_upper_follow: assert property (
        ((object_irq_flags_upper & object_irq_enables_upper) != 8'h00)
        |=> obj_irq_req)
        else $error("request not raised for an enabled pending upper object");

    a_irq_req_drop: assert property (
        ((object_irq_flags_upper & object_irq_enables_upper) == 8'h00
        && (object_irq_flags_lower & object_irq_enables_lower) == 8'h00)
        |=> !obj_irq_req)
        else $error("request stayed high with nothing enabled and pending");

    a_req_all_masked: assert property (
        (object_irq_enables_upper == 8'h00 && object_irq_enables_lower == 8'h00)
        |=> !obj_irq_req)
        else $error("request raised with every object disabled");

    a_req_rise_cause: assert property (
        $rose(obj_irq_req) |-> $past(((object_irq_flags_upper & object_irq_enables_upper)
        | (object_irq_flags_lower & object_irq_enables_lower)) != 8'h00))
        else $error("request rose without an enabled pending object");

    a_req_fall_cause: assert property (
        $fell(obj_irq_req) |-> $past(((object_irq_flags_upper & object_irq_enables_upper)
        | (object_irq_flags_lower & object_irq_enables_lower)) == 8'h00))
        else $error("request fell while an enabled object was pending");

    // prescaler field as software sees it
    a_presc_write: assert property (
        (sfr_wr && sfr_addr == `COI_ADDR_BT1)
        |=> baud_prescaler_field == $past(sfr_wdata[6:1]))
        else $error("prescaler field did not take bits 6 to 1");

    a_presc_hold: assert property (
        !(sfr_wr && sfr_addr == `COI_ADDR_BT1) |=> $stable(baud_prescaler_field))
        else $error("prescaler field changed without a write");

    a_bt1_reserved_zero: assert property (
        (sfr_rd && sfr_addr == `COI_ADDR_BT1)
        |=> sfr_rdata[7] == 1'b0 && sfr_rdata[0] == 1'b0
        && sfr_rdata[6:1] == $past(baud_prescaler_field))
        else $error("prescaler read back wrongly");

    a_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
        rst |-> object_irq_enables_upper == 8'h00
        && object_irq_flags_upper == 8'h00
        && object_irq_enables_lower == 8'h00
        && object_irq_flags_lower == 8'h00
        && baud_prescaler_field == 6'h00 && !obj_irq_req)
        else $error("registers not cleared during reset");

    // main scenarios reached by the bench
    c_irq_raised: cover property ($rose(obj_irq_req));

    c_enable_written: cover property (
        sfr_wr && sfr_addr == `COI_ADDR_EN_HI && sfr_wdata == 8'h0c);

    c_status_read: cover property (
        sfr_rd && sfr_addr == `COI_ADDR_STAT_HI ##1 sfr_rdata == 8'h09);

    c_object_cleared: cover property ($fell(object_irq_flags_upper[6]));

endmodule : coi_top

// ===== bench/coi_core_model.sv
`timescale 1ns/1ps

module coi_core_model
(
    input wire logic clk,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata
);
    initial
    begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end

    // bench calls this at any point of a test; reserved bits forced low
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d & ((a == 8'hb4) ? 8'h7e : (a == 8'hc2) ? 8'h7f : 8'hff);
        sfr_wr = 1'b1;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #1;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        @(posedge clk);
        #1;
        d = sfr_rdata;
    endtask : rd_reg
endmodule : coi_core_model

// ===== bench/coi_top_bench.sv
`timescale 1ns/1ps
`include "coi_map.svh"

module coi_top_bench;
    logic clk;
    logic rst;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [14:0] obj_irq_cond;
    logic [7:0] sfr_rdata;
    logic obj_irq_req;
    logic scl_tick;
    logic [5:0] baud_prescaler_field;
    int fail_count = 0;
    int n_checks = 0;

    coi_top i_coi_top (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .obj_irq_cond(obj_irq_cond),
        .sfr_rdata(sfr_rdata), .obj_irq_req(obj_irq_req), .scl_tick(scl_tick),
        .baud_prescaler_field(baud_prescaler_field));

    coi_core_model i_coi_core_model (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("FAIL %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_coi_core_model.rd_reg(a, d);
        chk8(nm, e, d);
    endtask : rd_chk

    task automatic set_cond(input logic [14:0] c, input int n);
        @(posedge clk);
        #1;
        obj_irq_cond = c;
        repeat (n) @(posedge clk);
        #1;
    endtask : set_cond

    task automatic t_reset;
        rd_chk("prescaler", `COI_ADDR_BT1, 8'h00);
        rd_chk("status hi", `COI_ADDR_STAT_HI, 8'h00);
        rd_chk("status lo", `COI_ADDR_STAT_LO, 8'h00);
        rd_chk("enable hi", `COI_ADDR_EN_HI, 8'h00);
        rd_chk("enable lo", `COI_ADDR_EN_LO, 8'h00);
        chk1("request", 1'b0, obj_irq_req);
    endtask : t_reset

    task automatic t_enables;
        i_coi_core_model.wr_reg(`COI_ADDR_EN_LO, 8'h0c);
        rd_chk("enable lo", `COI_ADDR_EN_LO, 8'h0c);
        i_coi_core_model.wr_reg(`COI_ADDR_EN_HI, 8'h0c);
        rd_chk("enable hi", `COI_ADDR_EN_HI, 8'h0c);
        i_coi_core_model.wr_reg(`COI_ADDR_EN_LO, 8'ha5);
        rd_chk("enable lo", `COI_ADDR_EN_LO, 8'ha5);
    endtask : t_enables

    task automatic t_status;
        set_cond(15'h0901, 2);
        rd_chk("status hi", `COI_ADDR_STAT_HI, 8'h09);
        rd_chk("status lo", `COI_ADDR_STAT_LO, 8'h01);
        i_coi_core_model.wr_reg(`COI_ADDR_STAT_HI, 8'h00);
        i_coi_core_model.wr_reg(`COI_ADDR_STAT_LO, 8'hfe);
        rd_chk("status hi", `COI_ADDR_STAT_HI, 8'h09);
        rd_chk("status lo", `COI_ADDR_STAT_LO, 8'h01);
        rd_chk("unmapped", 8'h00, 8'h00);
        set_cond(15'h0000, 2);
        rd_chk("status hi", `COI_ADDR_STAT_HI, 8'h00);
        rd_chk("status lo", `COI_ADDR_STAT_LO, 8'h00);
    endtask : t_status

    task automatic t_irq;
        i_coi_core_model.wr_reg(`COI_ADDR_EN_LO, 8'h00);
        set_cond(15'h4200, 3);
        chk1("request", 1'b0, obj_irq_req);
        set_cond(15'h0800, 1);
        chk1("request", 1'b0, obj_irq_req);
        @(posedge clk);
        #1;
        chk1("request", 1'b1, obj_irq_req);
        i_coi_core_model.wr_reg(`COI_ADDR_EN_HI, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk1("request", 1'b0, obj_irq_req);
        i_coi_core_model.wr_reg(`COI_ADDR_EN_LO, 8'h80);
        set_cond(15'h0080, 3);
        chk1("request", 1'b1, obj_irq_req);
        set_cond(15'h0000, 3);
        chk1("request", 1'b0, obj_irq_req);
    endtask : t_irq

    task automatic t_presc(input logic [7:0] v, input int per);
        int n;
        i_coi_core_model.wr_reg(`COI_ADDR_BT1, v);
        chk8("prescaler field", {2'b00, v[6:1]}, {2'b00, baud_prescaler_field});
        rd_chk("prescaler", `COI_ADDR_BT1, v & 8'h7e);
        for (n = 0; n < 200 && scl_tick !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (scl_tick !== 1'b1 && n < 200);
        chk8("tick period", per[7:0], n[7:0]);
    endtask : t_presc

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial
    begin
        #100000;
        fail_count++;
        close_out();
    end

    initial
    begin
        // raise reset after time zero so the asynchronous reset edge is seen
        rst = 1'b0;
        obj_irq_cond = 15'h0000;
        #1;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_enables();
        t_status();
        t_irq();
        t_presc(8'h04, 3);
        t_presc(8'h7e, 64);
        t_presc(8'h00, 1);
        close_out();
    end
endmodule : coi_top_bench
